// ---- core/pfra_core.sv ----
// Contract
// - In-page branch loads six operand bits
// - Branch needs flag; skip sets flag
// - Preload page five bits, one cycle late
// - Preload bank from inverted output bit
// - Next cycle keeps old bank, page
// - Preload conditional; skip leaves flag zero
// - Preload then branch gives far branch
// - Table branch builds target from registers
// - Table bank is bank OR operand top
// - Table branch unconditional, flag untouched
// - Call pushes next address, shifts stack
// - Call goes bank 0 page 0
// - Return stack has four levels
// - Call needs flag; skip sets flag
// - Preload then call gives far call
// - RAM holds 256 four-bit digits
// - RAM indexed by file and digit
// - Sixteen fixed digits swap with accumulator
// - RAM read happens before write
// - Bit set, clear, test by operand
// - Flag captures not-zero, overflow, tests
// - Accumulator and carry take ALU result
// - Accumulator with carry rotates
// - Bank and page hold until reloaded
// - Address is 64-state polynomial counter
//
// The address map and the plain strobed port are this design's own decisions.
module pfra_core #(
  parameter int STACK_DEPTH = 4
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [9:0] instr_in,
  output logic [11:0] rom_addr_out,
  input wire logic [3:0] sw_addr_in,
  input wire logic [11:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [11:0] sw_rdata_out
);

  localparam int SW = 12 * STACK_DEPTH;

  logic bank_reg;
  logic [4:0] page_reg;
  logic [5:0] addr_reg;
  logic [3:0] acc_reg;
  logic [3:0] aux_reg;
  logic carry_reg;
  logic status_reg;
  logic [3:0] file_reg;
  logic [3:0] digit_reg;
  logic bank_sel_reg;
  logic pend_bank_reg;
  logic [4:0] pend_page_reg;
  pfra_pkg::pfra_pre_e pre_reg;
  logic [SW-1:0] stk_reg;
  logic [11:0] rdata_reg;
  logic [3:0] ram_reg [256];
  logic live_reg;

  // Decode
  pfra_pkg::pfra_op_e op;
  wire logic [2:0] sub = instr_in[2:0];
  wire logic [1:0] bsub = instr_in[5:4];
  wire logic [3:0] imm = instr_in[3:0];
  wire logic is_br;
  wire logic is_pre;
  wire logic is_tbr;
  wire logic is_ret;
  wire logic is_cal;
  wire logic is_bit;
  wire logic is_swp;
  wire logic is_alu;
  wire logic is_cy;
  wire logic armed;

  assign op = pfra_pkg::pfra_op_e'(instr_in[9:6]);
  assign is_br = op == pfra_pkg::OP_BRANCH_IN_PAGE;
  assign is_pre = op == pfra_pkg::OP_PAGE_PRELOAD;
  assign is_tbr = op == pfra_pkg::OP_TABLE_BRANCH;
  assign is_ret = op == pfra_pkg::OP_RETURN;
  assign is_cal = op == pfra_pkg::OP_SHORT_CALL;
  assign is_bit = op == pfra_pkg::OP_RAM_BIT;
  assign is_swp = op == pfra_pkg::OP_SWAP_FIXED;
  assign is_alu = op == pfra_pkg::OP_ALU;
  assign is_cy = op == pfra_pkg::OP_CARRY;
  assign armed = pre_reg == pfra_pkg::PRE_ARMED;

  wire logic br_go = is_br & status_reg;
  wire logic cal_go = is_cal & status_reg;
  wire logic pre_go = is_pre & status_reg;

  // RAM addressing, read before write
  wire logic [7:0] ram_idx = {file_reg, digit_reg};
  wire logic [7:0] fix_idx = {pfra_pkg::FIXED_FILE, imm};
  wire logic [7:0] mem_idx = is_swp ? fix_idx : ram_idx;
  wire logic [3:0] mem_rd = ram_reg[mem_idx];
  wire logic [3:0] bit_mask = 4'h1 << instr_in[1:0];
  wire logic bit_val = mem_rd[instr_in[1:0]];

  // ALU
  wire logic [4:0] sum = {1'h0, acc_reg} + {1'h0, mem_rd} + {4'h0, carry_reg};
  wire logic alu_add = is_alu & (sub == pfra_pkg::ALU_ADD);
  wire logic alu_lgc = is_alu & (sub >= pfra_pkg::ALU_AND) & (sub <= pfra_pkg::ALU_XOR);
  wire logic alu_ld = is_alu & ((sub == pfra_pkg::ALU_XCH) | (sub == pfra_pkg::ALU_LDM));
  wire logic alu_st = is_alu & ((sub == pfra_pkg::ALU_XCH) | (sub == pfra_pkg::ALU_STM));
  wire logic [3:0] lgc_res;
  wire logic cy_rotl = is_cy & (sub == pfra_pkg::CY_ROTL);
  wire logic cy_rotr = is_cy & (sub == pfra_pkg::CY_ROTR);

  assign lgc_res = (sub == pfra_pkg::ALU_AND) ? (acc_reg & mem_rd) :
                   (sub == pfra_pkg::ALU_OR) ? (acc_reg | mem_rd) :
                   (acc_reg ^ mem_rd);

  wire logic [3:0] acc_next;
  wire logic carry_next;
  wire logic status_next;

  assign acc_next = (is_swp | alu_ld) ? mem_rd :
                    alu_add ? sum[3:0] :
                    alu_lgc ? lgc_res :
                    cy_rotl ? {acc_reg[2:0], carry_reg} :
                    cy_rotr ? {carry_reg, acc_reg[3:1]} :
                    (op == pfra_pkg::OP_LOAD_ACC) ? imm :
                    acc_reg;

  assign carry_next = alu_add ? sum[4] :
                      (is_cy & (sub == pfra_pkg::CY_SET)) ? 1'h1 :
                      (is_cy & (sub == pfra_pkg::CY_CLR)) ? 1'h0 :
                      cy_rotl ? acc_reg[3] :
                      cy_rotr ? acc_reg[0] :
                      carry_reg;

  assign status_next = ((is_br | is_cal) & !status_reg) ? 1'h1 :
                       alu_add ? sum[4] :
                       alu_lgc ? (|lgc_res) :
                       (is_cy & (sub == pfra_pkg::CY_TEST)) ? carry_reg :
                       (is_bit & (bsub == pfra_pkg::BIT_TEST)) ? bit_val :
                       status_reg;

  // RAM write
  wire logic bit_wr = is_bit & (bsub != pfra_pkg::BIT_TEST);
  wire logic mem_we = is_swp | alu_st | bit_wr;
  wire logic [3:0] bit_res;
  wire logic [3:0] mem_wd;

  assign bit_res = (bsub == pfra_pkg::BIT_SET) ? (mem_rd | bit_mask) :
                   (mem_rd & ~bit_mask);
  assign mem_wd = bit_wr ? bit_res : acc_reg;

  // Polynomial address step
  wire logic fb = (addr_reg[5] ~^ addr_reg[4]) ^ (&addr_reg[4:0]);
  wire logic [5:0] addr_step = {addr_reg[4:0], fb};
  wire logic [11:0] ret_addr = {bank_reg, page_reg, addr_step};

  // Bank and page seen by this cycle
  wire logic base_bank = armed ? pend_bank_reg : bank_reg;
  wire logic [4:0] base_page = armed ? pend_page_reg : page_reg;

  // Table branch target
  wire logic [5:0] tbr_addr = {aux_reg[1:0], acc_reg};
  wire logic [4:0] tbr_page = page_reg | {aux_reg[3:2], carry_reg, instr_in[1:0]};
  wire logic tbr_bank = bank_reg | instr_in[2];

  wire logic bank_next;
  wire logic [4:0] page_next;
  wire logic [5:0] addr_next;

  assign bank_next = is_ret ? stk_reg[11] :
                     is_tbr ? tbr_bank :
                     (cal_go & !armed) ? 1'h0 :
                     base_bank;
  assign page_next = is_ret ? stk_reg[10:6] :
                     is_tbr ? tbr_page :
                     (cal_go & !armed) ? 5'h00 :
                     base_page;
  assign addr_next = is_ret ? stk_reg[5:0] :
                     is_tbr ? tbr_addr :
                     (br_go | cal_go) ? instr_in[5:0] :
                     addr_step;

  // Return stack, flat with level one in the low bits
  wire logic [SW-1:0] stk_next;

  assign stk_next = cal_go ? {stk_reg[SW-13:0], ret_addr} :
                    is_ret ? {stk_reg[SW-1 -: 12], stk_reg[SW-1:12]} :
                    stk_reg;

  // Software port decode
  wire logic wr_idx = sw_wr_in & (sw_addr_in == pfra_pkg::REG_INDEX);
  wire logic wr_ctl = sw_wr_in & (sw_addr_in == pfra_pkg::REG_CTRL);
  wire logic [3:0] file_next;
  wire logic [3:0] digit_next;
  wire logic [11:0] rd_sel;

  assign file_next = wr_idx ? sw_wdata_in[7:4] :
                     (op == pfra_pkg::OP_LOAD_FILE) ? imm :
                     file_reg;
  assign digit_next = wr_idx ? sw_wdata_in[3:0] :
                      (op == pfra_pkg::OP_LOAD_DIGIT) ? imm :
                      digit_reg;

  assign rd_sel = (sw_addr_in == pfra_pkg::REG_PC) ? {bank_reg, page_reg, addr_reg} :
                  (sw_addr_in == pfra_pkg::REG_CORE) ?
                    {2'h0, status_reg, carry_reg, aux_reg, acc_reg} :
                  (sw_addr_in == pfra_pkg::REG_INDEX) ? {4'h0, file_reg, digit_reg} :
                  (sw_addr_in == pfra_pkg::REG_CTRL) ? {11'h000, bank_sel_reg} :
                  (sw_addr_in == pfra_pkg::REG_STACK) ? stk_reg[11:0] :
                  (sw_addr_in == pfra_pkg::REG_RAM) ? {8'h00, ram_reg[ram_idx]} :
                  12'h000;

  // Program counter
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {bank_reg, page_reg, addr_reg} <= pfra_pkg::RST_PC;
    end else begin
      bank_reg <= bank_next;
      page_reg <= page_next;
      addr_reg <= addr_next;
    end
  end

  // Delayed preload
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_reg <= pfra_pkg::PRE_IDLE;
      pend_bank_reg <= 1'h0;
      pend_page_reg <= 5'h00;
    end else begin
      case (pre_go)
        1'h1: begin
          pre_reg <= pfra_pkg::PRE_ARMED;
          pend_bank_reg <= ~bank_sel_reg;
          pend_page_reg <= instr_in[4:0];
        end
        default: begin
          pre_reg <= pfra_pkg::PRE_IDLE;
        end
      endcase
    end
  end

  // Working registers
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_reg <= 4'h0;
      aux_reg <= 4'h0;
      carry_reg <= 1'h0;
      status_reg <= pfra_pkg::RST_STATUS;
    end else begin
      acc_reg <= acc_next;
      aux_reg <= (op == pfra_pkg::OP_LOAD_AUX) ? imm : aux_reg;
      carry_reg <= carry_next;
      status_reg <= status_next;
    end
  end

  // Index, control, stack, read data
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      file_reg <= 4'h0;
      digit_reg <= 4'h0;
      bank_sel_reg <= 1'h0;
      stk_reg <= '0;
      rdata_reg <= 12'h000;
    end else begin
      file_reg <= file_next;
      digit_reg <= digit_next;
      bank_sel_reg <= wr_ctl ? sw_wdata_in[0] : bank_sel_reg;
      stk_reg <= stk_next;
      rdata_reg <= sw_rd_in ? rd_sel : 12'h000;
    end
  end

  // Data RAM, one digit per entry
  for (genvar e = 0; e < 256; e++) begin : g_ram
    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        ram_reg[e] <= 4'h0;
      end else if (mem_we && (mem_idx == 8'(e))) begin
        ram_reg[e] <= mem_wd;
      end
    end
  end

  assign rom_addr_out = {bank_reg, page_reg, addr_reg};
  assign sw_rdata_out = rdata_reg;

  // Marks edges at which instructions really run; the edge that ends reset does not
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      live_reg <= 1'h0;
    end else begin
      live_reg <= 1'h1;
    end
  end

  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in || !live_reg);

  br_target_a : assert property (
    br_go && !armed |=> rom_addr_out == {$past(rom_addr_out[11:6]), $past(instr_in[5:0])})
    else $error("in-page branch target wrong");

  br_skip_a : assert property (
    is_br && !status_reg |=> status_reg && rom_addr_out[11:6] == $past(rom_addr_out[11:6]))
    else $error("skipped branch left flag clear");

  pre_hold_a : assert property (
    pre_go && !armed |=> rom_addr_out[11:6] == $past(rom_addr_out[11:6]))
    else $error("preload took effect too early");

  pre_load_a : assert property (
    pre_go ##1 !(is_tbr || is_ret || is_cal) |=>
      rom_addr_out[11:6] == {~$past(bank_sel_reg, 2), $past(instr_in[4:0], 2)})
    else $error("preload bank or page wrong");

  pre_skip_a : assert property (
    is_pre && !status_reg |=> !status_reg && !armed)
    else $error("skipped preload changed flag");

  far_branch_a : assert property (
    pre_go ##1 (is_br && status_reg) |=>
      rom_addr_out == {~$past(bank_sel_reg, 2), $past(instr_in[4:0], 2), $past(instr_in[5:0])})
    else $error("far branch target wrong");

  tbr_bank_a : assert property (
    is_tbr |=> rom_addr_out[11] == ($past(rom_addr_out[11]) | $past(instr_in[2])))
    else $error("table branch bank wrong");

  tbr_flag_a : assert property (
    is_tbr |=> $stable(status_reg) && rom_addr_out[5:0] == $past(tbr_addr))
    else $error("table branch disturbed flag");

  call_push_a : assert property (
    cal_go |=> stk_reg[11:0] == $past(ret_addr) && stk_reg[23:12] == $past(stk_reg[11:0]))
    else $error("call push wrong");

  call_target_a : assert property (
    cal_go && !armed |=> rom_addr_out == {6'h00, $past(instr_in[5:0])})
    else $error("short call target wrong");

  bit_test_a : assert property (
    is_bit && bsub == pfra_pkg::BIT_TEST |=> status_reg == $past(bit_val))
    else $error("bit test flag wrong");

  ret_pop_a : assert property (
    is_ret |=> rom_addr_out == $past(stk_reg[11:0]))
    else $error("return address wrong");

  stk_shift_a : assert property (
    cal_go |=> stk_reg[SW-1 -: 12] == $past(stk_reg[SW-13 -: 12]))
    else $error("stack shift wrong");

  skip_call_a : assert property (
    is_cal && !status_reg |=> status_reg && $stable(stk_reg))
    else $error("skipped call changed stack or flag");

  add_result_a : assert property (
    alu_add |=> {carry_reg, acc_reg} ==
      $past({1'h0, acc_reg} + {1'h0, mem_rd} + {4'h0, carry_reg}))
    else $error("add result or carry wrong");

  rot_left_a : assert property (
    cy_rotl |=> {acc_reg, carry_reg} ==
      $past({acc_reg[2:0], carry_reg, acc_reg[3]}))
    else $error("left rotate wrong");

  swap_fixed_a : assert property (
    is_swp |=> acc_reg == $past(ram_reg[fix_idx]) &&
      ram_reg[$past(fix_idx)] == $past(acc_reg))
    else $error("fixed digit swap wrong");

endmodule : pfra_core

// ---- core/pfra_pkg.sv ----
package pfra_pkg;

  // Instruction classes, taken from the top four bits of the word
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_PAGE_PRELOAD = 4'h1,
    OP_TABLE_BRANCH = 4'h2,
    OP_RETURN = 4'h3,
    OP_RAM_BIT = 4'h4,
    OP_SWAP_FIXED = 4'h5,
    OP_ALU = 4'h6,
    OP_CARRY = 4'h7,
    OP_LOAD_FILE = 4'h8,
    OP_LOAD_DIGIT = 4'h9,
    OP_LOAD_ACC = 4'hA,
    OP_LOAD_AUX = 4'hB,
    OP_BRANCH_IN_PAGE = 4'hC,
    OP_SHORT_CALL = 4'hD
  } pfra_op_e;

  // Delayed bank and page load
  typedef enum logic {
    PRE_IDLE = 1'h0,
    PRE_ARMED = 1'h1
  } pfra_pre_e;

  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_AND = 3'h1;
  localparam logic [2:0] ALU_OR = 3'h2;
  localparam logic [2:0] ALU_XOR = 3'h3;
  localparam logic [2:0] ALU_XCH = 3'h4;
  localparam logic [2:0] ALU_LDM = 3'h5;
  localparam logic [2:0] ALU_STM = 3'h6;

  localparam logic [2:0] CY_SET = 3'h0;
  localparam logic [2:0] CY_CLR = 3'h1;
  localparam logic [2:0] CY_TEST = 3'h2;
  localparam logic [2:0] CY_ROTL = 3'h3;
  localparam logic [2:0] CY_ROTR = 3'h4;

  localparam logic [1:0] BIT_SET = 2'h0;
  localparam logic [1:0] BIT_CLR = 2'h1;
  localparam logic [1:0] BIT_TEST = 2'h2;

  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_CORE = 4'h1;
  localparam logic [3:0] REG_INDEX = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam logic [3:0] REG_STACK = 4'h4;
  localparam logic [3:0] REG_RAM = 4'h5;

  localparam logic [3:0] FIXED_FILE = 4'hF;
  localparam logic [11:0] RST_PC = 12'h03F;
  localparam logic RST_STATUS = 1'h1;

endpackage : pfra_pkg

// ---- tb/pfra_rom_model.sv ----
module pfra_rom_model (
  input wire logic [11:0] addr_in,
  output logic [9:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Program store with a combinational read, loaded by the bench
  logic [9:0] mem [4096];

  assign data_out = mem[addr_in];

endmodule : pfra_rom_model

// ---- tb/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock_in;
  logic nrst_in;
  logic sw_wr_in;
  logic sw_rd_in;
  logic [3:0] sw_addr_in;
  logic [11:0] sw_wdata_in;
  logic [11:0] rom_addr_out;
  logic [11:0] sw_rdata_out;
  logic [11:0] pc;
  logic [9:0] instr_in;
  logic [9:0] w [$];
  int error_cnt = 0;
  int compares = 0;

  pfra_rom_model rom (.addr_in(rom_addr_out), .data_out(instr_in));

  pfra_core dut (.clock_in(clock_in), .nrst_in(nrst_in), .instr_in(instr_in),
    .rom_addr_out(rom_addr_out), .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
    .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  function automatic logic [5:0] nxt(input logic [5:0] a);
    return {a[4:0], ~(a[5] ^ a[4]) ^ (&a[4:0])};
  endfunction : nxt

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Program words go along the counter sequence from 03F
  task automatic restart();
    logic [5:0] a;
    a = 6'h3F;
    for (int i = 0; i < 4096; i++) rom.mem[i] = 10'h000;
    foreach (w[i]) begin
      rom.mem[{6'h00, a}] = w[i];
      a = nxt(a);
    end
    @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    #1;
    pc = 12'h03F;
    chk(rom_addr_out, 12'h03F);
  endtask : restart

  // One instruction; strobes set here are taken at the next edge
  task automatic cyc(input logic [11:0] exp, input logic wr = 1'b0, input logic rd = 1'b0,
                     input logic [3:0] a = 4'h0, input logic [11:0] d = 12'h000);
    @(posedge clock_in);
    sw_wr_in <= wr;
    sw_rd_in <= rd;
    sw_addr_in <= a;
    sw_wdata_in <= d;
    #1;
    pc = exp;
    chk(rom_addr_out, exp);
  endtask : cyc

  task automatic stp(input logic wr, input logic rd, input logic [3:0] a, input logic [11:0] d);
    cyc({pc[11:6], nxt(pc[5:0])}, wr, rd, a, d);
  endtask : stp

  task automatic seq(input int n);
    repeat (n) stp(1'b0, 1'b0, 4'h0, 12'h000);
  endtask : seq

  task automatic rd_chk(input logic [3:0] a, input logic [11:0] exp);
    stp(1'b0, 1'b1, a, 12'h000);
    seq(1);
    chk(sw_rdata_out, exp);
  endtask : rd_chk

  task automatic sc_skip();
    w = {10'h181, 10'h045, 10'h32A, 10'h311};
    restart();
    seq(3);
    cyc(12'h011);
    seq(1);
  endtask : sc_skip

  task automatic sc_far_branch();
    w = {10'h045, 10'h32A};
    restart();
    seq(1);
    cyc(12'h96A);
    seq(2);
  endtask : sc_far_branch

  task automatic sc_far_call();
    w = {10'h000, 10'h000, 10'h043, 10'h350};
    restart();
    rom.mem[12'h0C0] = 10'h0C0;
    stp(1'b1, 1'b0, pfra_pkg::REG_CTRL, 12'h001);
    seq(2);
    cyc(12'h0D0);
    rd_chk(pfra_pkg::REG_STACK, 12'h037);
    cyc(12'h037);
    chk(sw_rdata_out, 12'h000);
  endtask : sc_far_call

  task automatic sc_table();
    w = {10'h181, 10'h28A, 10'h2CD, 10'h1C0, 10'h085};
    restart();
    rom.mem[12'hF5A] = 10'h300;
    rom.mem[12'hF74] = 10'h080;
    rom.mem[12'hF40] = 10'h345;
    seq(4);
    cyc(12'hF5A);
    cyc(12'hF74);
    cyc(12'hF5A);
    cyc(12'hF40);
    cyc(12'h005);
    rd_chk(pfra_pkg::REG_STACK, 12'hF41);
  endtask : sc_table

  task automatic sc_ram();
    w = {10'h203, 10'h247, 10'h289, 10'h186, 10'h102, 10'h110,
         10'h121, 10'h300, 10'h285, 10'h184, 10'h142};
    restart();
    seq(11);
    rd_chk(pfra_pkg::REG_RAM, 12'h005);
    stp(1'b1, 1'b0, pfra_pkg::REG_INDEX, 12'h0F2);
    rd_chk(pfra_pkg::REG_RAM, 12'h00C);
    rd_chk(pfra_pkg::REG_INDEX, 12'h0F2);
    rd_chk(4'hF, 12'h000);
  endtask : sc_ram

  task automatic sc_alu();
    w = {10'h28C, 10'h186, 10'h287, 10'h1C0, 10'h180, 10'h000,
         10'h1C4, 10'h1C3, 10'h183, 10'h1C1, 10'h1C2, 10'h340};
    restart();
    seq(5);
    rd_chk(pfra_pkg::REG_CORE, 12'h304);
    seq(4);
    rd_chk(pfra_pkg::REG_CORE, 12'h208);
    rd_chk(pfra_pkg::REG_PC, {pc[11:6], nxt(pc[5:0])});
  endtask : sc_alu

  initial begin
    nrst_in = 1'b0;
    sw_wr_in = 1'b0;
    sw_rd_in = 1'b0;
    sw_addr_in = 4'h0;
    sw_wdata_in = 12'h000;
    pc = 12'h03F;
    sc_skip();
    sc_far_branch();
    sc_far_call();
    sc_table();
    sc_ram();
    sc_alu();
    print_verdict();
  end

endmodule : testbench
